// ---- design/iosbe_pkg.sv ----
// Constants, types and register map for the increment/OR/shift/branch execution unit
// How it works
// RQ1 - Destination bit 0 sends result to W, 1 writes back file register
// RQ2 - Increment-and-skip adds one, routes by destination, leaves flags alone
// RQ3 - Zero increment-and-skip result turns the next instruction into a NOP
// RQ4 - Jump loads its eleven-bit immediate into program counter bits 10..0
// RQ5 - Jump fills counter bits 14..11 from latch bits 6..3, no flags
// RQ6 - OR literal combines W with eight-bit immediate into W, updates Z
// RQ7 - Plain increment adds one, routes by destination, updates Z only
// RQ8 - OR file combines W with file operand, routes by destination, updates Z
// RQ9 - Left shift moves bit 7 into carry, bits 6..0 up one place
// RQ10 - Left shift inserts zero at bit 0 and routes by destination
// RQ11 - Zero flag set when eight-bit result is zero, cleared otherwise
// RQ12 - File operands decode as seven-bit address plus one destination bit
package iosbe_pkg;

  // Widths
  localparam int unsigned IOSBE_INSTR_W = 14;
  localparam int unsigned IOSBE_PC_W = 15;
  localparam int unsigned IOSBE_LATCH_W = 7;
  localparam int unsigned IOSBE_ADDR_W = 8;

  // Register byte offsets on the APB
  localparam logic [7:0] IOSBE_OFS_INSTR = 8'h00;
  localparam logic [7:0] IOSBE_OFS_WREG = 8'h04;
  localparam logic [7:0] IOSBE_OFS_OPERAND = 8'h08;
  localparam logic [7:0] IOSBE_OFS_RESULT = 8'h0c;
  localparam logic [7:0] IOSBE_OFS_STATUS = 8'h10;
  localparam logic [7:0] IOSBE_OFS_PC = 8'h14;
  localparam logic [7:0] IOSBE_OFS_LATCH = 8'h18;
  localparam logic [7:0] IOSBE_OFS_FADDR = 8'h1c;
  localparam logic [7:0] IOSBE_OFS_CYCLES = 8'h20;

  // Status register field positions
  localparam int unsigned IOSBE_ST_CARRY = 0;
  localparam int unsigned IOSBE_ST_ZERO = 1;
  localparam int unsigned IOSBE_ST_SKIP = 2;
  localparam int unsigned IOSBE_ST_FWB = 3;

  // Reset values
  localparam logic [7:0] IOSBE_RST_BYTE = 8'h00;
  localparam logic [14:0] IOSBE_RST_PC = 15'h0000;
  localparam logic [6:0] IOSBE_RST_LATCH = 7'h00;
  localparam logic [15:0] IOSBE_RST_CYCLES = 16'h0000;

  // Opcode fields, top six bits of the instruction word
  localparam logic [5:0] IOSBE_OPC_INCR_SKIP = 6'h0f;
  localparam logic [5:0] IOSBE_OPC_INCR = 6'h0a;
  localparam logic [5:0] IOSBE_OPC_OR_FILE = 6'h04;
  localparam logic [5:0] IOSBE_OPC_SHL = 6'h35;
  localparam logic [5:0] IOSBE_OPC_OR_LIT = 6'h38;
  // Jump is matched on the top three bits only
  localparam logic [2:0] IOSBE_OPC_JUMP = 3'h5;

  // Decoded instruction kinds
  typedef enum logic [2:0] {
    IOSBE_NOP,
    IOSBE_INCR_SKIP_ZERO_OP,
    IOSBE_INCR_FILE_OP,
    IOSBE_OR_FILE_OP,
    IOSBE_OR_LITERAL_OP,
    IOSBE_SHIFT_LEFT_LOGICAL_OP,
    IOSBE_JUMP_ABSOLUTE_OP
  } iosbe_kind_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } iosbe_apb_req_t;

  // Operand fields carried out of the instruction word
  typedef struct packed {
    logic dest;
    logic [6:0] faddr;
    logic [7:0] lit8;
    logic [10:0] lit11;
  } iosbe_fields_t;

endpackage

// ---- design/iosbe_core.sv ----
// Execution unit for increment, OR, left shift and absolute jump, with an APB slave
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module iosbe_core (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire iosbe_pkg::iosbe_apb_req_t apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic [14:0] program_counter,
  output logic [7:0] w_value,
  output logic skip_pending,
  output logic file_we,
  output logic [6:0] file_addr,
  output logic [7:0] file_wdata
);
  import iosbe_pkg::*;

  // Architectural state
  logic [13:0] instr_r;
  logic go_r;
  logic [7:0] w_r;
  logic [7:0] w_nxt;
  logic [7:0] operand_r;
  logic [7:0] result_r;
  logic [7:0] result_nxt;
  logic carry_r;
  logic carry_nxt;
  logic zero_r;
  logic zero_nxt;
  logic skip_r;
  logic skip_nxt;
  logic fwb_r;
  logic fwb_nxt;
  logic [14:0] pc_r;
  logic [14:0] pc_nxt;
  logic [6:0] latch_r;
  logic [6:0] faddr_r;
  logic [15:0] cycles_r;

  // Bus-facing registers
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic file_we_r;
  logic [6:0] file_addr_r;
  logic [7:0] file_wdata_r;

  // Bus phase decode
  wire setup_ph = apb_req.psel & ~apb_req.penable;
  wire access_ph = apb_req.psel & apb_req.penable & pready_r;
  wire wr_fire = access_ph & apb_req.pwrite & ~pslverr_r;

  // Address decode
  wire sel_instr = apb_req.paddr == IOSBE_OFS_INSTR;
  wire sel_wreg = apb_req.paddr == IOSBE_OFS_WREG;
  wire sel_operand = apb_req.paddr == IOSBE_OFS_OPERAND;
  wire sel_result = apb_req.paddr == IOSBE_OFS_RESULT;
  wire sel_status = apb_req.paddr == IOSBE_OFS_STATUS;
  wire sel_pc = apb_req.paddr == IOSBE_OFS_PC;
  wire sel_latch = apb_req.paddr == IOSBE_OFS_LATCH;
  wire sel_faddr = apb_req.paddr == IOSBE_OFS_FADDR;
  wire sel_cycles = apb_req.paddr == IOSBE_OFS_CYCLES;
  // Result, address and cycle count are read-only; writing them is an error
  wire sel_ro = sel_result | sel_faddr | sel_cycles;
  wire sel_rw = sel_instr | sel_wreg | sel_operand | sel_status | sel_pc | sel_latch;
  // Misaligned or unmapped offsets miss every select and report an error
  wire addr_bad = ~(sel_ro | sel_rw) | (apb_req.pwrite & sel_ro);

  // Status word as software sees it
  wire [31:0] status_word = {28'h0000000, fwb_r, skip_r, zero_r, carry_r};

  // Read data mux
  wire [31:0] rd_mux =
    sel_instr ? {18'h00000, instr_r} :
    sel_wreg ? {24'h000000, w_r} :
    sel_operand ? {24'h000000, operand_r} :
    sel_result ? {24'h000000, result_r} :
    sel_status ? status_word :
    sel_pc ? {17'h00000, pc_r} :
    sel_latch ? {25'h0000000, latch_r} :
    sel_faddr ? {25'h0000000, faddr_r} :
    sel_cycles ? {16'h0000, cycles_r} :
    32'h00000000;

  // Operand field extraction
  iosbe_fields_t fld;
  // RQ12 address and destination
  assign fld = '{
    dest: instr_r[7],
    faddr: instr_r[6:0],
    lit8: instr_r[7:0],
    lit11: instr_r[10:0]
  };

  // Opcode match
  wire [5:0] opc = instr_r[13:8];
  wire is_jump = instr_r[13:11] == IOSBE_OPC_JUMP;
  wire is_incsz = opc == IOSBE_OPC_INCR_SKIP;
  wire is_inc = opc == IOSBE_OPC_INCR;
  wire is_orf = opc == IOSBE_OPC_OR_FILE;
  wire is_orl = opc == IOSBE_OPC_OR_LIT;
  wire is_shl = opc == IOSBE_OPC_SHL;

  // Kind selection; a pending skip squashes whatever was issued
  // Unknown opcodes fall through to NOP and still advance the PC
  iosbe_kind_t kind;
  // RQ3 squash to NOP
  assign kind = skip_r ? IOSBE_NOP :
    is_jump ? IOSBE_JUMP_ABSOLUTE_OP :
    is_incsz ? IOSBE_INCR_SKIP_ZERO_OP :
    is_inc ? IOSBE_INCR_FILE_OP :
    is_orf ? IOSBE_OR_FILE_OP :
    is_orl ? IOSBE_OR_LITERAL_OP :
    is_shl ? IOSBE_SHIFT_LEFT_LOGICAL_OP :
    IOSBE_NOP;

  // Arithmetic and logic results, all eight bits wide
  wire [7:0] inc_sum = operand_r + 8'h01;
  wire [7:0] or_file = w_r | operand_r;
  // RQ6 literal OR
  wire [7:0] or_lit = w_r | fld.lit8;
  // RQ9 shift up one
  wire [7:0] shl_val = {operand_r[6:0], 1'b0};
  // RQ9 bit 7 to carry
  wire shl_carry = operand_r[7];

  // Jump target
  // RQ4 low eleven bits
  // RQ5 upper four from latch
  wire [14:0] jump_pc = {latch_r[6:3], fld.lit11};
  // Sequential flow wraps at the top of the 15-bit space
  wire [14:0] pc_inc = pc_r + 15'h0001;

  // Execute strobe; ce freezes it with everything else
  wire exec = go_r & ce;

  // Next-state logic for one executed instruction
  always_comb begin
    logic [7:0] res;
    logic file_kind;
    logic upd_z;
    logic upd_c;
    // Defaults describe a NOP: no flag moves, no write-back, PC steps on
    res = IOSBE_RST_BYTE;
    file_kind = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    skip_nxt = 1'b0;
    pc_nxt = pc_inc;
    case (kind)
      // RQ2 increment, no flags
      IOSBE_INCR_SKIP_ZERO_OP: begin
        res = inc_sum;
        file_kind = 1'b1;
        // RQ3 zero result skips next
        skip_nxt = inc_sum == 8'h00;
      end
      // RQ7 increment, Z only
      IOSBE_INCR_FILE_OP: begin
        res = inc_sum;
        file_kind = 1'b1;
        upd_z = 1'b1;
      end
      // RQ8 OR with file
      IOSBE_OR_FILE_OP: begin
        res = or_file;
        file_kind = 1'b1;
        upd_z = 1'b1;
      end
      IOSBE_OR_LITERAL_OP: begin
        res = or_lit;
        upd_z = 1'b1;
      end
      // RQ10 zero in, routed
      IOSBE_SHIFT_LEFT_LOGICAL_OP: begin
        res = shl_val;
        file_kind = 1'b1;
        upd_z = 1'b1;
        upd_c = 1'b1;
      end
      // RQ5 jump, flags untouched
      IOSBE_JUMP_ABSOLUTE_OP: begin
        pc_nxt = jump_pc;
      end
      default: begin
        res = IOSBE_RST_BYTE;
      end
    endcase
    result_nxt = res;
    // RQ1 destination routing
    w_nxt = (kind == IOSBE_OR_LITERAL_OP || (file_kind && !fld.dest)) ? res : w_r;
    file_kind = file_kind & fld.dest;
    // RQ11 zero flag from result
    zero_nxt = upd_z ? (res == 8'h00) : zero_r;
    carry_nxt = upd_c ? shl_carry : carry_r;
    fwb_nxt = file_kind;
  end

  // Write-back indication derived from the same decode
  wire wb_file = fwb_nxt;

  // Bus slave: ready and read data are prepared in the setup cycle, so every
  // access completes with no wait state and prdata comes from a flop
  // ce low freezes these flops too, so ce should not drop mid-transfer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      pready_r <= setup_ph;
      prdata_r <= (setup_ph && !apb_req.pwrite) ? rd_mux : 32'h00000000;
      pslverr_r <= setup_ph & addr_bad;
    end
  end

  // Instruction capture; go pulses for one cycle after the write lands
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      instr_r <= 14'h0000;
      go_r <= 1'b0;
    end else if (ce) begin
      go_r <= wr_fire & sel_instr;
      if (wr_fire && sel_instr) begin
        instr_r <= apb_req.pwdata[13:0];
      end
    end
  end

  // Working register; execution and a software write never share a cycle,
  // but execution is given priority in case a master tries
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      w_r <= IOSBE_RST_BYTE;
    end else if (exec) begin
      w_r <= w_nxt;
    end else if (ce && wr_fire && sel_wreg) begin
      w_r <= apb_req.pwdata[7:0];
    end
  end

  // File operand supplied by software before each file instruction
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      operand_r <= IOSBE_RST_BYTE;
    end else if (ce && wr_fire && sel_operand) begin
      operand_r <= apb_req.pwdata[7:0];
    end
  end

  // Flags; software may preload carry and zero through the status word
  // A status write in the go cycle loses to execution and is dropped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      carry_r <= 1'b0;
      zero_r <= 1'b0;
    end else if (exec) begin
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
    end else if (ce && wr_fire && sel_status) begin
      carry_r <= apb_req.pwdata[IOSBE_ST_CARRY];
      zero_r <= apb_req.pwdata[IOSBE_ST_ZERO];
    end
  end

  // Skip flag lives across exactly one issued instruction
  // A squashed slot clears it, so back-to-back skips need two zero results
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      skip_r <= 1'b0;
    end else if (exec) begin
      // RQ3 set or consume
      skip_r <= skip_nxt;
    end
  end

  // Program counter and its latch
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= IOSBE_RST_PC;
    end else if (exec) begin
      pc_r <= pc_nxt;
    end else if (ce && wr_fire && sel_pc) begin
      pc_r <= apb_req.pwdata[14:0];
    end
  end

  // Latch feeds the jump target and is read back over the APB; nothing else reads it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latch_r <= IOSBE_RST_LATCH;
    end else if (ce && wr_fire && sel_latch) begin
      latch_r <= apb_req.pwdata[6:0];
    end
  end

  // Result capture and file write port; the pulse lasts one cycle
  // file_addr follows every executed slot, write-back or not
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= IOSBE_RST_BYTE;
      faddr_r <= 7'h00;
      fwb_r <= 1'b0;
      file_we_r <= 1'b0;
      file_addr_r <= 7'h00;
      file_wdata_r <= IOSBE_RST_BYTE;
    end else if (ce) begin
      // RQ1 write back when dest is 1
      file_we_r <= exec & wb_file;
      if (exec) begin
        result_r <= result_nxt;
        faddr_r <= fld.faddr;
        fwb_r <= wb_file;
        file_addr_r <= fld.faddr;
        file_wdata_r <= result_nxt;
      end
    end
  end

  // Executed cycle count; a squashed NOP costs a cycle, so a skip shows as two
  // The count wraps silently; software should read it as a difference
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cycles_r <= IOSBE_RST_CYCLES;
    end else if (exec) begin
      cycles_r <= cycles_r + 16'h0001;
    end
  end

  // Outputs straight from flops
  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign program_counter = pc_r;
  assign w_value = w_r;
  assign skip_pending = skip_r;
  assign file_we = file_we_r;
  assign file_addr = file_addr_r;
  assign file_wdata = file_wdata_r;

endmodule

// ---- tb/iosbe_core_asserts.sv ----
// Port-level checks on the execution unit
`timescale 1ns/1ps
module iosbe_core_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire iosbe_pkg::iosbe_apb_req_t apb_req,
  input wire logic pready,
  input wire logic [14:0] program_counter,
  input wire logic [7:0] w_value,
  input wire logic skip_pending,
  input wire logic file_we,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_wdata
);
  import iosbe_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Instruction word landing at an access edge; it runs at the next edge
  wire instr_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && pready && ce
    && apb_req.paddr == IOSBE_OFS_INSTR;
  wire [5:0] opc = apb_req.pwdata[13:8];
  wire dst = apb_req.pwdata[7];
  wire fop = opc == IOSBE_OPC_INCR || opc == IOSBE_OPC_INCR_SKIP
    || opc == IOSBE_OPC_OR_FILE || opc == IOSBE_OPC_SHL;
  sequence s_issue;
    instr_wr && !skip_pending;
  endsequence
  sequence s_squash;
    instr_wr && skip_pending;
  endsequence
  a_dest_route: assert property (s_issue ##0 fop |-> ##2 file_we == $past(dst, 2))
    else $error("destination routing wrong");
  a_skip_keeps_w: assert property (
    s_issue ##0 opc == IOSBE_OPC_INCR_SKIP && dst |-> ##2 w_value == $past(w_value, 2))
    else $error("increment-skip to file changed W");
  a_skip_arm: assert property (
    s_issue ##0 opc == IOSBE_OPC_INCR_SKIP && !dst |-> ##2 skip_pending == (w_value == 8'h00))
    else $error("skip flag does not follow zero result");
  a_squash_nop: assert property (s_squash |-> ##2 !skip_pending && !file_we
    && w_value == $past(w_value, 2) && program_counter == $past(program_counter, 2) + 15'h1)
    else $error("squashed instruction had an effect");
  a_jump_low: assert property (
    s_issue ##0 opc[5:3] == IOSBE_OPC_JUMP
      |-> ##2 program_counter[10:0] == $past(apb_req.pwdata[10:0], 2))
    else $error("jump target low bits wrong");
  a_or_literal: assert property (
    s_issue ##0 opc == IOSBE_OPC_OR_LIT
      |-> ##2 w_value == ($past(w_value, 2) | $past(apb_req.pwdata[7:0], 2)))
    else $error("literal OR result wrong");
  a_or_file_bits: assert property (
    s_issue ##0 opc == IOSBE_OPC_OR_FILE && !dst
      |-> ##2 (w_value & $past(w_value, 2)) == $past(w_value, 2))
    else $error("file OR lost a W bit");
  a_shift_lsb: assert property (
    s_issue ##0 opc == IOSBE_OPC_SHL && dst |-> ##2 file_we && !file_wdata[0])
    else $error("left shift bit 0 not zero");
  a_addr_field: assert property (
    s_issue ##0 fop |-> ##2 file_addr == $past(apb_req.pwdata[6:0], 2))
    else $error("file address field wrong");
endmodule

bind iosbe_core iosbe_core_asserts iosbe_core_asserts_i (.mclk(mclk), .rst_b(rst_b),
  .ce(ce), .apb_req(apb_req), .pready(pready), .program_counter(program_counter),
  .w_value(w_value), .skip_pending(skip_pending), .file_we(file_we),
  .file_addr(file_addr), .file_wdata(file_wdata));

// ---- tb/iosbe_core_bench.sv ----
// Self-checking bench for the execution unit, driven over APB
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module iosbe_core_bench;
  import iosbe_pkg::*;
  logic mclk, rst_b, ce, pready, pslverr, skip_pending, file_we, er;
  iosbe_apb_req_t apb_req;
  logic [31:0] prdata, rd, cyc;
  logic [14:0] program_counter;
  logic [7:0] w_value, file_wdata, fw_data;
  logic [6:0] file_addr;
  int mismatches, n_tests, fw_cnt, n;
  iosbe_core iosbe_core_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .apb_req(apb_req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .program_counter(program_counter),
    .w_value(w_value), .skip_pending(skip_pending), .file_we(file_we),
    .file_addr(file_addr), .file_wdata(file_wdata));
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Capture write-back pulses; they stand for one cycle only
  always @(posedge mclk) begin
    if (file_we === 1'b1) begin
      fw_cnt++;
      fw_data = file_wdata;
    end
  end
  task print_verdict;
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      print_verdict;
    end
    rd = prdata;
    er = pslverr;
    apb_req <= '0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] x, input string s);
    apb(1'b0, a, 32'h0);
    `CHK(s, x, rd)
  endtask
  task op(input logic [13:0] ins);
    wr(IOSBE_OFS_INSTR, {18'h0, ins});
  endtask
  task t_or_lit;
    wr(IOSBE_OFS_WREG, 32'h0);
    op({IOSBE_OPC_OR_LIT, 8'h00});
    rchk(IOSBE_OFS_STATUS, 32'h2, "status");
    wr(IOSBE_OFS_WREG, 32'h50);
    op({IOSBE_OPC_OR_LIT, 8'ha5});
    rchk(IOSBE_OFS_WREG, 32'hf5, "w");
    rchk(IOSBE_OFS_STATUS, 32'h0, "status");
  endtask
  task t_incr;
    wr(IOSBE_OFS_STATUS, 32'h1);
    wr(IOSBE_OFS_OPERAND, 32'hff);
    op({IOSBE_OPC_INCR, 1'b0, 7'h55});
    rchk(IOSBE_OFS_WREG, 32'h0, "w");
    rchk(IOSBE_OFS_STATUS, 32'h3, "status");
    `CHK("faddr", 7'h55, file_addr)
    wr(IOSBE_OFS_WREG, 32'h33);
    wr(IOSBE_OFS_OPERAND, 32'h41);
    n = fw_cnt;
    op({IOSBE_OPC_INCR, 1'b1, 7'h2a});
    rchk(IOSBE_OFS_STATUS, 32'h9, "status");
    rchk(IOSBE_OFS_WREG, 32'h33, "w");
    `CHK("fw count", n + 1, fw_cnt)
    `CHK("fw data", 8'h42, fw_data)
  endtask
  task t_skip;
    wr(IOSBE_OFS_STATUS, 32'h1);
    wr(IOSBE_OFS_PC, 32'h100);
    wr(IOSBE_OFS_OPERAND, 32'hff);
    apb(1'b0, IOSBE_OFS_CYCLES, 32'h0);
    cyc = rd;
    op({IOSBE_OPC_INCR_SKIP, 1'b0, 7'h01});
    rchk(IOSBE_OFS_STATUS, 32'h5, "status");
    `CHK("skip", 1'b1, skip_pending)
    op({IOSBE_OPC_OR_LIT, 8'hff});
    rchk(IOSBE_OFS_WREG, 32'h0, "w");
    rchk(IOSBE_OFS_PC, 32'h102, "pc");
    rchk(IOSBE_OFS_CYCLES, cyc + 32'h2, "cycles");
    wr(IOSBE_OFS_OPERAND, 32'h10);
    op({IOSBE_OPC_INCR_SKIP, 1'b1, 7'h02});
    rchk(IOSBE_OFS_WREG, 32'h0, "w");
    `CHK("skip", 1'b0, skip_pending)
    `CHK("fw data", 8'h11, fw_data)
  endtask
  task t_or_file;
    wr(IOSBE_OFS_STATUS, 32'h0);
    wr(IOSBE_OFS_WREG, 32'h0f);
    wr(IOSBE_OFS_OPERAND, 32'hf0);
    op({IOSBE_OPC_OR_FILE, 1'b0, 7'h03});
    rchk(IOSBE_OFS_WREG, 32'hff, "w");
    wr(IOSBE_OFS_WREG, 32'h0);
    wr(IOSBE_OFS_OPERAND, 32'h0);
    op({IOSBE_OPC_OR_FILE, 1'b1, 7'h04});
    rchk(IOSBE_OFS_STATUS, 32'ha, "status");
    `CHK("fw data", 8'h00, fw_data)
  endtask
  task t_shift;
    wr(IOSBE_OFS_STATUS, 32'h2);
    wr(IOSBE_OFS_OPERAND, 32'h81);
    op({IOSBE_OPC_SHL, 1'b0, 7'h05});
    rchk(IOSBE_OFS_WREG, 32'h02, "w");
    rchk(IOSBE_OFS_STATUS, 32'h1, "status");
    wr(IOSBE_OFS_OPERAND, 32'h80);
    n = fw_cnt;
    op({IOSBE_OPC_SHL, 1'b1, 7'h06});
    rchk(IOSBE_OFS_STATUS, 32'hb, "status");
    `CHK("fw data", 8'h00, fw_data)
    `CHK("fw count", n + 1, fw_cnt)
  endtask
  task t_jump;
    wr(IOSBE_OFS_STATUS, 32'h3);
    wr(IOSBE_OFS_LATCH, 32'h5a);
    op({IOSBE_OPC_JUMP, 11'h7ff});
    rchk(IOSBE_OFS_PC, 32'h5fff, "pc");
    rchk(IOSBE_OFS_STATUS, 32'h3, "status");
    wr(IOSBE_OFS_LATCH, 32'h07);
    op({IOSBE_OPC_JUMP, 11'h2c3});
    rchk(IOSBE_OFS_PC, 32'h02c3, "pc");
  endtask
  // Refused accesses: a read-only place and a hole in the map
  task t_bus;
    wr(IOSBE_OFS_RESULT, 32'h55);
    `CHK("slverr", 1'b1, er)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, er)
  endtask
  // Clock enable low holds a written instruction until it rises again
  task t_freeze;
    wr(IOSBE_OFS_PC, 32'h10);
    wr(IOSBE_OFS_WREG, 32'h01);
    wr(IOSBE_OFS_STATUS, 32'h2);
    op({IOSBE_OPC_OR_LIT, 8'h00});
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("pc frozen", 15'h010, program_counter)
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("pc", 15'h011, program_counter)
    rchk(IOSBE_OFS_STATUS, 32'h0, "status");
  endtask
  initial begin
    rst_b = 1'b0;
    apb_req = '0;
    ce = 1'b1;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rchk(IOSBE_OFS_PC, 32'h0, "pc");
    t_or_lit;
    t_incr;
    t_skip;
    t_or_file;
    t_shift;
    t_jump;
    t_bus;
    t_freeze;
    print_verdict;
  end
endmodule
